// >>> hdl/omcs_top.sv
// Behaviour
// - transmit_disable high turns the laser off; low enables it.
// - transmit_disable reads high until a low is seen, so laser starts off.
// - 2-wire transactions are answered only while module_deselect_n is low.
// - target address is 7-bit 1010000; last address bit selects read or write.
// - attention output asserts on a new condition; host reads details over 2-wire.
// - module_absent is held low, the pin is grounded inside the module.
// - module_not_ready is high on operational fault, low in normal operation.
// - receive_signal_lost is high while optical input power is too low.
// - power-down/reset high keeps low-power mode; normal operation only when low.
// - power-down/reset falling edge resets internal logic to initial state, except the syncs, power mode, condition tracking and receive_signal_lost.
// - not-ready equals transmit loss-of-lock OR receive loss-of-lock.
// - not-ready follows its fault condition after about 20 ms.
`timescale 1ns/100ps
`default_nettype none
`include "omcs_defines.svh"

module omcs_top
    import omcs_pkg::*;
#(
    parameter int NR_DELAY_CYCLES = `OMCS_NR_DELAY_MS * `OMCS_CLK_KHZ
) (
    // clock and reset
    input  wire logic    clk_i,
    input  wire logic    srst_i,
    // host control pins
    input  wire logic    transmit_disable_i,
    input  wire logic    power_down_reset_i,
    input  wire logic    module_deselect_n_i,
    // 2-wire management pins
    input  wire logic    scl_i,
    input  wire logic    sda_i,
    output var  logic    sda_o,
    output var  logic    sda_oe_o,
    // internal module conditions
    input  wire omcs_cond_type cond_i,
    // status pins to host
    output var  logic    attention_out_n_o,
    output var  logic    module_not_ready_o,
    output var  logic    receive_signal_lost_o,
    output var  logic    module_absent_o,
    // module internals
    output var  logic    laser_enable_o,
    output var  logic    low_power_o,
    output var  logic    core_reset_o
);

    // counter end point; the delay counts cycles of disagreement only
    localparam logic [`OMCS_NR_CNT_W-1:0] NR_LAST = `OMCS_NR_CNT_W'(NR_DELAY_CYCLES - 1);

    // initial values; syncs idle at the pulled-up level
    // so no false edge follows a reset on a pin that sits at its idle high level
    localparam omcs_state_type INIT = '{
        sync1:     `OMCS_SYNC_RST,
        sync2:     `OMCS_SYNC_RST,
        prev:      `OMCS_SYNC_RST,
        tw:        OMCS_TW_IDLE,
        bit_cnt:   4'h0,
        shift:     8'h00,
        rw:        1'b0,
        got_ack:   1'b0,
        sda_oe:    1'b0,
        sda:       1'b0,
        rst_cnt:   `OMCS_RST_CNT_W'(0),
        nr_cnt:    `OMCS_NR_CNT_W'(0),
        nr_out:    1'b0,
        los_out:   1'b0,
        attn:      1'b0,
        cond_prev: `OMCS_COND_W'(0),
        laser_en:  1'b0,
        low_power: 1'b1,
        core_rst:  1'b0,
        absent:    1'b0
    };

    omcs_state_type state;
    omcs_state_type next_state;

    // decoded pin views, taken from the second sync stage and the edge stage
    logic                    txdis;
    logic                    pdr;
    logic                    selected;
    logic                    scl_now;
    logic                    scl_prev;
    logic                    sda_now;
    logic                    sda_prev;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    bus_start;
    logic                    bus_stop;
    logic                    pdr_fall;
    logic                    resetting;
    logic [`OMCS_COND_W-1:0] cond_now;
    logic                    nr_raw;
    logic [7:0]              status_byte;

    // edge and level decode; first sync stage never read here
    always_comb begin
        txdis     = state.sync2[`OMCS_IN_TXDIS];
        pdr       = state.sync2[`OMCS_IN_PDR];
        selected  = ~state.sync2[`OMCS_IN_DESEL];
        scl_now   = state.sync2[`OMCS_IN_SCL];
        scl_prev  = state.prev[`OMCS_IN_SCL];
        sda_now   = state.sync2[`OMCS_IN_SDA];
        sda_prev  = state.prev[`OMCS_IN_SDA];
        scl_rise  = scl_now & ~scl_prev;
        scl_fall  = ~scl_now & scl_prev;
        bus_start = scl_now & scl_prev & sda_prev & ~sda_now;
        bus_stop  = scl_now & scl_prev & ~sda_prev & sda_now;
        pdr_fall  = ~pdr & state.prev[`OMCS_IN_PDR];
        resetting = (state.rst_cnt != `OMCS_RST_CNT_W'(0));
        cond_now  = '0;
        cond_now[`OMCS_COND_TXLOL] = cond_i.tx_lol;
        cond_now[`OMCS_COND_RXLOL] = cond_i.rx_lol;
        cond_now[`OMCS_COND_LOS]   = cond_i.rx_power_low;
        nr_raw    = cond_i.tx_lol | cond_i.rx_lol;
        // details of the attention condition for the host
        status_byte = {4'h0, state.attn, cond_now};
    end

    // next-state logic for the whole block
    always_comb begin
        next_state = state;

        // two-stage synchroniser plus one stage for edges
        next_state.sync1 = {sda_i, scl_i, module_deselect_n_i, power_down_reset_i, transmit_disable_i};
        next_state.sync2 = state.sync1;
        next_state.prev  = state.sync2;

        // pin-level control of laser and power mode
        next_state.laser_en  = ~txdis & ~pdr & ~resetting;
        next_state.low_power = pdr;
        next_state.core_rst  = resetting;
        next_state.absent    = 1'b0;
        next_state.sda       = 1'b0;
        next_state.los_out   = cond_i.rx_power_low;

        // not-ready only moves once the fault has held its new level
        if (nr_raw != state.nr_out) begin
            if (state.nr_cnt == NR_LAST) begin
                next_state.nr_out = nr_raw;
                next_state.nr_cnt = '0;
            end else begin
                next_state.nr_cnt = state.nr_cnt + `OMCS_NR_CNT_W'(1);
            end
        end else begin
            next_state.nr_cnt = '0; // glitches shorter than the delay are dropped
        end

        // new conditions latch attention; set wins over a read-clear below
        next_state.cond_prev = cond_now;

        // 2-wire target state machine
        unique case (state.tw)
            OMCS_TW_IDLE: begin
                // nothing to do until a start is seen
                next_state.sda_oe = 1'b0;
            end
            OMCS_TW_ADDR: begin
                // bits arrive msb first on the synced rising edge
                if (scl_rise) begin
                    next_state.shift   = {state.shift[6:0], sda_now};
                    next_state.bit_cnt = state.bit_cnt + 4'h1;
                end else if (scl_fall && state.bit_cnt == `OMCS_BITS_PER_BYTE) begin
                    // ack only our address, only when selected and not resetting
                    if (state.shift[7:1] == `OMCS_DEV_ADDR && selected && !resetting) begin
                        next_state.rw     = state.shift[`OMCS_RW_BIT];
                        next_state.sda_oe = 1'b1;
                        next_state.tw     = OMCS_TW_ACK_A;
                    end else begin
                        next_state.tw = OMCS_TW_IDLE;
                    end
                end
            end
            OMCS_TW_ACK_A: begin
                if (scl_fall) begin
                    next_state.bit_cnt = 4'h0;
                    if (state.rw) begin
                        // open drain: enable pulls low for a zero bit
                        next_state.shift  = status_byte;
                        next_state.sda_oe = ~status_byte[`OMCS_MSB];
                        next_state.tw     = OMCS_TW_READ;
                    end else begin
                        next_state.sda_oe = 1'b0;
                        next_state.tw     = OMCS_TW_WRITE;
                    end
                end
            end
            OMCS_TW_WRITE: begin
                // no writable map here; bytes are acked and dropped
                if (scl_rise) begin
                    next_state.shift   = {state.shift[6:0], sda_now};
                    next_state.bit_cnt = state.bit_cnt + 4'h1;
                end else if (scl_fall && state.bit_cnt == `OMCS_BITS_PER_BYTE) begin
                    next_state.sda_oe = 1'b1;
                    next_state.tw     = OMCS_TW_ACK_W;
                end
            end
            OMCS_TW_ACK_W: begin
                if (scl_fall) begin
                    next_state.sda_oe  = 1'b0;
                    next_state.bit_cnt = 4'h0;
                    next_state.tw      = OMCS_TW_WRITE;
                end
            end
            OMCS_TW_READ: begin
                // next bit goes out after a fall and stands through the high phase
                if (scl_fall) begin
                    next_state.bit_cnt = state.bit_cnt + 4'h1;
                    if (state.bit_cnt == `OMCS_BITS_PER_BYTE - 4'h1) begin
                        // byte delivered: host has seen the details
                        next_state.sda_oe  = 1'b0;
                        next_state.attn    = 1'b0;
                        next_state.got_ack = 1'b0;
                        next_state.tw      = OMCS_TW_ACK_R;
                    end else begin
                        next_state.shift  = {state.shift[6:0], 1'b0};
                        next_state.sda_oe = ~state.shift[`OMCS_MSB-1];
                    end
                end
            end
            OMCS_TW_ACK_R: begin
                // host ack on the ninth clock asks for a fresh snapshot
                if (scl_rise) begin
                    next_state.got_ack = ~sda_now;
                    if (sda_now) begin
                        next_state.tw = OMCS_TW_IDLE; // host nack ends the read
                    end
                end else if (scl_fall && state.got_ack) begin
                    next_state.bit_cnt = 4'h0;
                    next_state.shift   = status_byte;
                    next_state.sda_oe  = ~status_byte[`OMCS_MSB];
                    next_state.tw      = OMCS_TW_READ;
                end
            end
            default: begin
                next_state.tw     = OMCS_TW_IDLE;
                next_state.sda_oe = 1'b0;
            end
        endcase

        // start and stop override any byte in flight
        if (bus_start) begin
            next_state.tw      = OMCS_TW_ADDR;
            next_state.bit_cnt = 4'h0;
            next_state.shift   = 8'h00;
            next_state.sda_oe  = 1'b0;
        end else if (bus_stop || !selected) begin
            // deselect drops off the bus at once so another module can talk
            next_state.tw     = OMCS_TW_IDLE;
            next_state.sda_oe = 1'b0;
        end

        // attention set placed after the 2-wire machine so it beats the read-clear
        if ((cond_now & ~state.cond_prev) != `OMCS_COND_W'(0)) begin
            next_state.attn = 1'b1;
        end

        // falling edge of power-down/reset: all restarts but the syncs, low_power, cond_prev and los_out
        // the counter keeps running so the internal reset ends on its own
        if (pdr_fall || resetting) begin
            next_state           = INIT;
            next_state.sync1     = {sda_i, scl_i, module_deselect_n_i, power_down_reset_i, transmit_disable_i};
            next_state.sync2     = state.sync1;
            next_state.prev      = state.sync2;
            next_state.low_power = pdr;
            next_state.core_rst  = 1'b1;
            next_state.cond_prev = cond_now;
            next_state.los_out   = cond_i.rx_power_low;
            next_state.rst_cnt   = pdr_fall ? `OMCS_RST_CYCLES
                                            : state.rst_cnt - `OMCS_RST_CNT_W'(1);
        end
    end

    // single state register, synchronous reset
    // no async branch, so reset only ever loads constants
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= INIT;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    // no gating here, so pins never glitch between edges
    always_comb begin
        sda_o                 = state.sda;
        sda_oe_o              = state.sda_oe;
        attention_out_n_o     = ~state.attn;
        module_not_ready_o    = state.nr_out;
        receive_signal_lost_o = state.los_out;
        module_absent_o       = state.absent;
        laser_enable_o        = state.laser_en;
        low_power_o           = state.low_power;
        core_reset_o          = state.core_rst;
    end

endmodule

`default_nettype wire

// >>> hdl/omcs_defines.svh
`ifndef OMCS_DEFINES_SVH
`define OMCS_DEFINES_SVH

// clock rate and not-ready response time
`define OMCS_CLK_KHZ        50000
`define OMCS_NR_DELAY_MS    20
`define OMCS_NR_CNT_W       20

// internal reset length after a power-down/reset falling edge
`define OMCS_RST_CYCLES     4'hF
`define OMCS_RST_CNT_W      4

// synchroniser lanes for host pins
`define OMCS_IN_W           5
`define OMCS_IN_TXDIS       0
`define OMCS_IN_PDR         1
`define OMCS_IN_DESEL       2
`define OMCS_IN_SCL         3
`define OMCS_IN_SDA         4
// pulled-up pins idle high: transmitter off, low power, deselected, bus idle
`define OMCS_SYNC_RST       5'h1F

// 2-wire target address and byte framing
`define OMCS_DEV_ADDR       7'h50
`define OMCS_RW_BIT         0
`define OMCS_BITS_PER_BYTE  4'h8
`define OMCS_MSB            7

// condition lanes: tx lol, rx lol, receive_signal_lost
`define OMCS_COND_W         3
`define OMCS_COND_TXLOL     0
`define OMCS_COND_RXLOL     1
`define OMCS_COND_LOS       2

`endif

// >>> hdl/omcs_pkg.sv
`include "omcs_defines.svh"

package omcs_pkg;

    // one-hot 2-wire target states
    typedef enum logic [6:0] {
        OMCS_TW_IDLE  = 7'h01,
        OMCS_TW_ADDR  = 7'h02,
        OMCS_TW_ACK_A = 7'h04,
        OMCS_TW_WRITE = 7'h08,
        OMCS_TW_ACK_W = 7'h10,
        OMCS_TW_READ  = 7'h20,
        OMCS_TW_ACK_R = 7'h40
    } omcs_tw_state_type;

    // internal condition inputs travel together
    typedef struct packed {
        logic tx_lol;
        logic rx_lol;
        logic rx_power_low;
    } omcs_cond_type;

    // whole state of the control block
    typedef struct packed {
        logic [`OMCS_IN_W-1:0]      sync1;
        logic [`OMCS_IN_W-1:0]      sync2;
        logic [`OMCS_IN_W-1:0]      prev;
        omcs_tw_state_type          tw;
        logic [3:0]                 bit_cnt;
        logic [7:0]                 shift;
        logic                       rw;
        logic                       got_ack;
        logic                       sda_oe;
        logic                       sda;
        logic [`OMCS_RST_CNT_W-1:0] rst_cnt;
        logic [`OMCS_NR_CNT_W-1:0]  nr_cnt;
        logic                       nr_out;
        logic                       los_out;
        logic                       attn;
        logic [`OMCS_COND_W-1:0]    cond_prev;
        logic                       laser_en;
        logic                       low_power;
        logic                       core_rst;
        logic                       absent;
    } omcs_state_type;

endpackage

// >>> test/omcs_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module omcs_top_props
    import omcs_pkg::*;
#(
    parameter int NR_DELAY_CYCLES = 8
) (
    // clock and reset
    input wire logic          clk_i,
    input wire logic          srst_i,
    // host pins and conditions
    input wire logic          transmit_disable_i,
    input wire logic          power_down_reset_i,
    input wire logic          module_deselect_n_i,
    input wire omcs_cond_type cond_i,
    // design outputs
    input wire logic          sda_oe_o,
    input wire logic          attention_out_n_o,
    input wire logic          module_not_ready_o,
    input wire logic          receive_signal_lost_o,
    input wire logic          module_absent_o,
    input wire logic          laser_enable_o,
    input wire logic          low_power_o,
    input wire logic          core_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // cycles the fault level has disagreed with not-ready; internal reset forces agreement
    int diff_cnt;
    always_ff @(posedge clk_i) begin
        if (srst_i || core_reset_o || ((cond_i.tx_lol | cond_i.rx_lol) == module_not_ready_o)) begin
            diff_cnt <= 0;
        end else begin
            diff_cnt <= diff_cnt + 1;
        end
    end
    sequence s_pdr_fall; power_down_reset_i ##1 !power_down_reset_i; endsequence
    sequence s_desel_held; module_deselect_n_i [*4]; endsequence
    property p_laser; laser_enable_o |-> !$past(transmit_disable_i, 3); endproperty
    a_laser: assert property (p_laser) else $error("laser on while disable was high");
    property p_low_power; !$past(srst_i, 3) |-> low_power_o == $past(power_down_reset_i, 3); endproperty
    a_low_power: assert property (p_low_power) else $error("low power does not follow pin");
    property p_rst_start; s_pdr_fall |-> ##[2:5] core_reset_o; endproperty
    a_rst_start: assert property (p_rst_start) else $error("no internal reset after falling edge");
    property p_rst_len; $rose(core_reset_o) |-> core_reset_o [*8] ##1 core_reset_o [*8] ##1 !core_reset_o; endproperty
    a_rst_len: assert property (p_rst_len) else $error("internal reset length wrong");
    property p_no_ack; core_reset_o |-> !sda_oe_o; endproperty
    a_no_ack: assert property (p_no_ack) else $error("data pulled during internal reset");
    property p_desel; s_desel_held |-> !sda_oe_o; endproperty
    a_desel: assert property (p_desel) else $error("data pulled while deselected");
    property p_absent; !module_absent_o; endproperty
    a_absent: assert property (p_absent) else $error("presence pin not grounded");
    property p_los; !$past(srst_i) && !core_reset_o |-> receive_signal_lost_o == $past(cond_i.rx_power_low); endproperty
    a_los: assert property (p_los) else $error("signal lost output wrong");
    property p_attn; (|(cond_i & ~$past(cond_i))) && !$past(srst_i) && !core_reset_o |=> !attention_out_n_o; endproperty
    a_attn: assert property (p_attn) else $error("attention not raised");
    property p_nr_wait; $changed(module_not_ready_o) && !core_reset_o |-> diff_cnt >= NR_DELAY_CYCLES - 1; endproperty
    a_nr_wait: assert property (p_nr_wait) else $error("not ready changed too early");
    property p_nr_follow; diff_cnt <= NR_DELAY_CYCLES + 2; endproperty
    a_nr_follow: assert property (p_nr_follow) else $error("not ready ignores lock loss");
endmodule
bind omcs_top omcs_top_props #(.NR_DELAY_CYCLES(NR_DELAY_CYCLES)) props_u (
    .clk_i(clk_i), .srst_i(srst_i), .transmit_disable_i(transmit_disable_i),
    .power_down_reset_i(power_down_reset_i), .module_deselect_n_i(module_deselect_n_i),
    .cond_i(cond_i), .sda_oe_o(sda_oe_o), .attention_out_n_o(attention_out_n_o),
    .module_not_ready_o(module_not_ready_o), .receive_signal_lost_o(receive_signal_lost_o),
    .module_absent_o(module_absent_o), .laser_enable_o(laser_enable_o),
    .low_power_o(low_power_o), .core_reset_o(core_reset_o));
`default_nettype wire

// >>> test/omcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module omcs_host_model (
    // clock and wire level
    input  wire logic clk_i,
    input  wire logic sda_i,
    // open-drain host drivers
    output var  logic scl_o,
    output var  logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // phases far longer than the module's sync lag
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one scl pulse; data moves only a few cycles after the fall
    task automatic pulse();
        wt(10);
        scl_o = 1'b1;
        wt(10);
        scl_o = 1'b0;
        wt(3);
    endtask
    task automatic start();
        wt(10);
        sda_low_o = 1'b1;
        wt(10);
        scl_o = 1'b0;
        wt(3);
    endtask
    // msb first, ack taken late in the ninth high phase
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_o = ~b[i];
            pulse();
        end
        sda_low_o = 1'b0;
        wt(10);
        scl_o = 1'b1;
        wt(10);
        ack = ~sda_i;
        scl_o = 1'b0;
        wt(3);
    endtask
    task automatic recv(input logic ack_in, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            wt(10);
            scl_o = 1'b1;
            wt(10);
            b[i] = sda_i;
            scl_o = 1'b0;
            wt(3);
        end
        sda_low_o = ack_in;
        pulse();
        sda_low_o = 1'b0;
    endtask
    task automatic stop();
        wt(3);
        sda_low_o = 1'b1;
        wt(10);
        scl_o = 1'b1;
        wt(10);
        sda_low_o = 1'b0;
        wt(10);
    endtask
endmodule
`default_nettype wire

// >>> test/optical_module_control_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module optical_module_control_status_tb_top
    import omcs_pkg::*;
;
    localparam int NR = 8;
    // host pins start at their pulled-up idle level
    logic          clk_i = 1'b0;
    logic          srst_i = 1'b1;
    logic          transmit_disable = 1'b1;
    logic          pdr = 1'b1;
    logic          desel = 1'b1;
    omcs_cond_type cond = '0;
    logic          ack, sda_oe, sda_d, attn_n, nr, los, absent, laser, lowp, crst;
    logic [7:0]    rbyte;
    logic [31:0]   r;
    logic [2:0]    prev = '0;
    logic [8:0]    tbl [4] = '{9'h1A0, 9'h0A3, 9'h021, 9'h0E1};
    int            err_count = 0;
    int            total_checks = 0;
    int            seed = 96;
    int            attn = 0;
    wire logic     scl, host_low;
    wire logic     sda_w = ~(host_low | sda_oe); // pull-up when nobody pulls
    always #10 clk_i = ~clk_i;
    omcs_host_model host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
    omcs_top #(.NR_DELAY_CYCLES(NR)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .transmit_disable_i(transmit_disable), .power_down_reset_i(pdr),
        .module_deselect_n_i(desel), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
        .cond_i(cond), .attention_out_n_o(attn_n), .module_not_ready_o(nr),
        .receive_signal_lost_o(los), .module_absent_o(absent), .laser_enable_o(laser),
        .low_power_o(lowp), .core_reset_o(crst));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one cycle of conditions through the reference model
    task automatic cyc(input logic [2:0] c);
        cond = c;
        tick(1);
        if (|(c & ~prev)) attn = 1;
        prev = c;
        `CHK(los, cond.rx_power_low)
        `CHK(attn_n, ~attn[0])
    endtask
    // one 2-wire transaction; reads end with a host nack
    task automatic xfer(input logic [7:0] a, input logic exp_ack);
        host_u.start();
        host_u.send(a, ack);
        `CHK(ack, exp_ack)
        if (exp_ack && a[0]) begin
            host_u.recv(1'b0, rbyte);
            `CHK(rbyte, {4'h0, attn[0], cond.rx_power_low, cond.rx_lol, cond.tx_lol})
            attn = 0;
        end else if (exp_ack) begin
            host_u.send(r[7:0], ack);
            `CHK(ack, 1'b1)
        end
        host_u.stop();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, several times the expected run
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        tick(16);
        srst_i = 1'b0;
        tick(4);
        `CHK(laser, 1'b0)
        `CHK(lowp, 1'b1)
        `CHK(absent, 1'b0)
        pdr = 1'b0;
        tick(6);
        `CHK(crst, 1'b1)
        `CHK(lowp, 1'b0)
        tick(20);
        `CHK(crst, 1'b0)
        transmit_disable = 1'b0;
        tick(2);
        `CHK(laser, 1'b0)
        tick(1);
        `CHK(laser, 1'b1)
        repeat (60) begin
            r = $random(seed);
            cyc(r[2:0]);
        end
        cyc(3'h0);
        tick(NR + 3);
        `CHK(nr, 1'b0)
        cyc(3'h4);
        tick(NR - 3);
        `CHK(nr, 1'b0)
        tick(5);
        `CHK(nr, 1'b1)
        cyc(3'h2);
        tick(NR + 3);
        `CHK(nr, 1'b1)
        cyc(3'h0);
        tick(NR + 3);
        `CHK(nr, 1'b0)
        xfer(8'hA1, 1'b0);
        desel = 1'b0;
        tick(4);
        xfer(8'hA1, 1'b1);
        tick(3);
        `CHK(attn_n, 1'b1)
        foreach (tbl[i]) begin
            r = $random(seed);
            xfer(tbl[i][7:0], tbl[i][8]);
        end
        // two-byte read: host ack asks for a second, fresh status byte
        cyc(3'h5);
        host_u.start();
        host_u.send(8'hA1, ack);
        `CHK(ack, 1'b1)
        for (int k = 1; k >= 0; k--) begin
            host_u.recv(k[0], rbyte);
            `CHK(rbyte, {4'h0, attn[0], cond.rx_power_low, cond.rx_lol, cond.tx_lol})
            attn = 0;
        end
        host_u.stop();
        `CHK(sda_d, 1'b0)
        `CHK(attn_n, 1'b1)
        pdr = 1'b1;
        tick(4);
        `CHK(lowp, 1'b1)
        `CHK(laser, 1'b0)
        results();
    end
endmodule
`default_nettype wire
